// File: core/enccl_chan.sv
/*
 * enccl_chan - one 32-bit up/down counting channel: quadrature decode in
 * encoder mode, pulse/direction counting in counter mode.
 * Assumes: inputs in the interface are synchronous to clk_in.
 */
`timescale 1ns/1ps

module enccl_chan
    import enccl_pkg::*;
(
    input  wire logic    clk_in,
    input  wire logic    rst_n_in,
    enccl_chan_if.chan   ch
);
    logic            a_p_r;
    logic            b_p_r;
    enccl_count_type count_r;
    enccl_count_type count_nxt;
    logic            a_chg;
    logic            b_chg;

    assign a_chg    = ch.a ^ a_p_r;
    assign b_chg    = ch.b ^ b_p_r;
    assign ch.count = count_r;

    // ======================================================================
    // previous track levels
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_p_r <= 1'b0;
            b_p_r <= 1'b0;
        end else begin
            a_p_r <= ch.a;
            b_p_r <= ch.b;
        end
    end

    // ======================================================================
    // next count; a software load beats a pulse in the same cycle
    always_comb begin
        count_nxt = count_r;
        if (ch.load) begin
            count_nxt = ch.load_val;
        end else if (ch.mode == ENCCL_MODE_COUNTER) begin
            if (ch.a && !a_p_r && ch.gate_en) begin
                count_nxt = ch.b ? count_r - 32'h0000_0001 : count_r + 32'h0000_0001;
            end
        end else if (!ch.freeze && (a_chg != b_chg)) begin
            // exactly one track moved; both moving means a lost step
            count_nxt = (ch.a ^ b_p_r) ? count_r + 32'h0000_0001
                                       : count_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= 32'h0000_0000;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ======================================================================
    // checks
    a_illegal_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ch.mode == ENCCL_MODE_ENCODER && !ch.load && a_chg && b_chg) |=> $stable(count_r))
        else $error("count moved on a double track change");

    a_count_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ch.mode == ENCCL_MODE_ENCODER && !ch.load && !ch.freeze && a_chg && !b_chg
         && (ch.a ^ b_p_r) && count_r == 32'hFFFF_FFFF) |=> count_r == 32'h0000_0000)
        else $error("count did not wrap to zero at full scale");
endmodule

// File: core/enccl_top.sv
/*
 * enccl_top - encoder counter/latch block with an AHB-Lite register slave.
 * Assumes: encoder pins are asynchronous; one AHB-Lite master; 125 MHz clock.
 */
// Notes on behaviour
// - zero-mark rising edge latches count when enabled in encoder mode
// - gate rising edge latches count when enabled in encoder mode
// - gate falling edge latches count when enabled in encoder mode
// - feature bit selects mode; A counts pulses
// - counter mode: B high down, low up
// - counter mode: C gates counting; gate ignored
// - second channel counts its own A/B pair
// - count is a 32-bit up/down register
// - selected gate level freezes the counter in encoder mode
`timescale 1ns/1ps
`include "enccl_cfg.svh"

module enccl_top
    import enccl_pkg::*;
(
    input  wire logic        MCLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        ENC_A_IN,
    input  wire logic        ENC_B_IN,
    input  wire logic        ENC_C_IN,
    input  wire logic        GATE_IN,
    input  wire logic        ENC_A2_IN,
    input  wire logic        ENC_B2_IN
);
    logic [`ENCCL_PIN_W-1:0] pin_s1_r;
    logic [`ENCCL_PIN_W-1:0] pin_s2_r;
    logic [`ENCCL_PIN_W-1:0] pin_p_r;
    logic [31:0]             ctrl_r;
    logic [31:0]             feature_r;
    enccl_count_type         latch_r;
    logic                    latched_r;
    logic                    wr_pend_r;
    logic [7:0]              wr_addr_r;
    logic                    acc;
    logic [31:0]             rd_mux;
    logic                    wr_now;
    logic                    c_rise;
    logic                    g_rise;
    logic                    g_fall;
    logic                    gate_lvl;
    logic                    latch_evt;
    enccl_mode_type          mode;

    enccl_chan_if ch0 ();
    enccl_chan_if ch1 ();

    // ======================================================================
    // pin synchronisers; edges are taken only from the second stage
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_p_r  <= 6'h00;
        end else begin
            pin_s1_r <= {ENC_B2_IN, ENC_A2_IN, GATE_IN, ENC_C_IN, ENC_B_IN, ENC_A_IN};
            pin_s2_r <= pin_s1_r;
            pin_p_r  <= pin_s2_r;
        end
    end

    assign gate_lvl = pin_s2_r[`ENCCL_PIN_GATE];
    assign c_rise   = pin_s2_r[`ENCCL_PIN_C] & ~pin_p_r[`ENCCL_PIN_C];
    assign g_rise   = gate_lvl & ~pin_p_r[`ENCCL_PIN_GATE];
    assign g_fall   = ~gate_lvl & pin_p_r[`ENCCL_PIN_GATE];
    assign mode     = feature_r[`ENCCL_FEAT_MODE] ? ENCCL_MODE_COUNTER
                                                  : ENCCL_MODE_ENCODER;

    // ======================================================================
    // channels
    assign ch0.a        = pin_s2_r[`ENCCL_PIN_A];
    assign ch0.b        = pin_s2_r[`ENCCL_PIN_B];
    assign ch0.mode     = mode;
    assign ch0.gate_en  = pin_s2_r[`ENCCL_PIN_C];
    // the gate pin has no function in counter mode, lock included
    assign ch0.freeze   = (feature_r[`ENCCL_FEAT_LOCK_HIGH] & gate_lvl)
                        | (feature_r[`ENCCL_FEAT_LOCK_LOW] & ~gate_lvl);
    assign ch0.load     = wr_now && wr_addr_r == `ENCCL_ADDR_COUNT;
    assign ch0.load_val = HWDATA_IN;

    // second channel: quadrature only, no zero mark and no gate
    assign ch1.a        = pin_s2_r[`ENCCL_PIN_A2];
    assign ch1.b        = pin_s2_r[`ENCCL_PIN_B2];
    assign ch1.mode     = ENCCL_MODE_ENCODER;
    assign ch1.gate_en  = 1'b1;
    assign ch1.freeze   = 1'b0;
    assign ch1.load     = wr_now && wr_addr_r == `ENCCL_ADDR_COUNT2;
    assign ch1.load_val = HWDATA_IN;

    enccl_chan u_chan0 (
        .clk_in   (MCLK_IN),
        .rst_n_in (ARST_N_IN),
        .ch       (ch0)
    );

    enccl_chan u_chan1 (
        .clk_in   (MCLK_IN),
        .rst_n_in (ARST_N_IN),
        .ch       (ch1)
    );

    // ======================================================================
    // reference-mark latch; latching is an encoder-mode feature only
    assign latch_evt = (mode == ENCCL_MODE_ENCODER)
                     && ((c_rise && ctrl_r[`ENCCL_CTRL_ZERO_LATCH])
                      || (g_rise && ctrl_r[`ENCCL_CTRL_RISE_LATCH])
                      || (g_fall && ctrl_r[`ENCCL_CTRL_FALL_LATCH]));

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            latch_r <= 32'h0000_0000;
        end else if (latch_evt) begin
            latch_r <= ch0.count;
        end
    end

    // sticky flag: a new mark wins over a clear in the same cycle
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            latched_r <= 1'b0;
        end else if (latch_evt) begin
            latched_r <= 1'b1;
        end else if (wr_now && wr_addr_r == `ENCCL_ADDR_STATUS
                     && HWDATA_IN[`ENCCL_STAT_LATCHED]) begin
            latched_r <= 1'b0;
        end
    end

    // ======================================================================
    // AHB-Lite slave, zero wait states, always OKAY
    assign acc    = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign wr_now = wr_pend_r && HREADY_IN;

    always_comb begin
        if (HADDR_IN[7:0] == `ENCCL_ADDR_CTRL) begin
            rd_mux = ctrl_r;
        end else if (HADDR_IN[7:0] == `ENCCL_ADDR_FEATURE) begin
            rd_mux = feature_r;
        end else if (HADDR_IN[7:0] == `ENCCL_ADDR_COUNT) begin
            rd_mux = ch0.count;
        end else if (HADDR_IN[7:0] == `ENCCL_ADDR_LATCH) begin
            rd_mux = latch_r;
        end else if (HADDR_IN[7:0] == `ENCCL_ADDR_STATUS) begin
            rd_mux = {27'h0000000, pin_s2_r[`ENCCL_PIN_GATE:`ENCCL_PIN_A], latched_r};
        end else if (HADDR_IN[7:0] == `ENCCL_ADDR_COUNT2) begin
            rd_mux = ch1.count;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (HREADY_IN) begin
            wr_pend_r <= acc && HWRITE_IN;
            wr_addr_r <= HADDR_IN[7:0];
        end
    end

    // read data registered at the end of the address phase
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            if (acc && !HWRITE_IN) begin
                HRDATA_OUT <= rd_mux;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ctrl_r    <= `ENCCL_CTRL_RST;
            feature_r <= `ENCCL_FEAT_RST;
        end else if (wr_now) begin
            if (wr_addr_r == `ENCCL_ADDR_CTRL) begin
                ctrl_r <= HWDATA_IN;
            end else if (wr_addr_r == `ENCCL_ADDR_FEATURE) begin
                feature_r <= HWDATA_IN;
            end
        end
    end

    // ======================================================================
    // checks
    logic c_gate_open;
    logic a_rise_s;
    assign c_gate_open = pin_s2_r[`ENCCL_PIN_C];
    assign a_rise_s    = pin_s2_r[`ENCCL_PIN_A] & ~pin_p_r[`ENCCL_PIN_A];

    sequence s_cnt_pulse;
        mode == ENCCL_MODE_COUNTER && !ch0.load && c_gate_open && a_rise_s;
    endsequence

    a_zero_latch: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (mode == ENCCL_MODE_ENCODER && c_rise && ctrl_r[`ENCCL_CTRL_ZERO_LATCH])
        |=> latch_r == $past(ch0.count))
        else $error("zero mark did not latch the count");

    a_rise_latch: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (mode == ENCCL_MODE_ENCODER && g_rise && ctrl_r[`ENCCL_CTRL_RISE_LATCH])
        |=> latch_r == $past(ch0.count)
        && latched_r)
        else $error("gate rising edge did not latch the count");

    a_fall_latch: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (mode == ENCCL_MODE_ENCODER && g_fall && ctrl_r[`ENCCL_CTRL_FALL_LATCH])
        |=> latch_r == $past(ch0.count)
        && latched_r)
        else $error("gate falling edge did not latch the count");

    a_pulse_up: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (s_cnt_pulse and !pin_s2_r[`ENCCL_PIN_B])
        |=> ch0.count == $past(ch0.count) + 32'h0000_0001)
        else $error("counter mode pulse did not count up");

    a_pulse_down: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (s_cnt_pulse and pin_s2_r[`ENCCL_PIN_B])
        |=> ch0.count == $past(ch0.count) - 32'h0000_0001)
        else $error("counter mode pulse did not count down");

    a_gate_closed: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (mode == ENCCL_MODE_COUNTER && !ch0.load && !c_gate_open) |=> $stable(ch0.count)
        && $stable(latch_r))
        else $error("count or latch moved with the counter gate closed");

    a_chan2_step: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (!ch1.load && pin_s2_r[5:4] == 2'b01 && pin_p_r[5:4] == 2'b00)
        |=> ch1.count == $past(ch1.count) + 32'h0000_0001)
        else $error("second channel missed a forward step");

    a_gate_lock: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
        (mode == ENCCL_MODE_ENCODER && !ch0.load && feature_r[`ENCCL_FEAT_LOCK_HIGH] && gate_lvl)
        |=> $stable(ch0.count))
        else $error("count moved while locked by the gate level");
endmodule

// File: inc/enccl_cfg.svh
/*
 * enccl_cfg.svh - register offsets, field positions and reset values of the
 * encoder counter/latch block.
 * Assumes: included by bare name from the package and the design modules.
 */
`ifndef ENCCL_CFG_SVH
`define ENCCL_CFG_SVH

// ==========================================================================
// register byte offsets (low address byte, one aligned word each)
`define ENCCL_ADDR_CTRL      8'h00
`define ENCCL_ADDR_FEATURE   8'h04
`define ENCCL_ADDR_COUNT     8'h08
`define ENCCL_ADDR_LATCH     8'h0C
`define ENCCL_ADDR_STATUS    8'h10
`define ENCCL_ADDR_COUNT2    8'h14

// ==========================================================================
// control register fields
`define ENCCL_CTRL_ZERO_LATCH  0
`define ENCCL_CTRL_RISE_LATCH  3
`define ENCCL_CTRL_FALL_LATCH  4
`define ENCCL_CTRL_RST         32'h0000_0000

// ==========================================================================
// feature register fields
`define ENCCL_FEAT_MODE        15
`define ENCCL_FEAT_LOCK_HIGH   5
`define ENCCL_FEAT_LOCK_LOW    4
`define ENCCL_FEAT_RST         32'h0000_0000

// ==========================================================================
// status register fields
`define ENCCL_STAT_LATCHED     0
`define ENCCL_STAT_PIN_LSB     1

// ==========================================================================
// widths and pin vector positions
`define ENCCL_CNT_W            32
`define ENCCL_PIN_W            6
`define ENCCL_PIN_A            0
`define ENCCL_PIN_B            1
`define ENCCL_PIN_C            2
`define ENCCL_PIN_GATE         3
`define ENCCL_PIN_A2           4
`define ENCCL_PIN_B2           5

`endif

// File: inc/enccl_if.sv
/*
 * enccl_chan_if - bundle between the top and one counting channel.
 * Assumes: a, b and gate are already synchronised to the block clock.
 */
`timescale 1ns/1ps

interface enccl_chan_if;
    import enccl_pkg::*;
    logic             a;
    logic             b;
    logic             gate_en;
    logic             freeze;
    logic             load;
    enccl_mode_type   mode;
    enccl_count_type  load_val;
    enccl_count_type  count;

    modport top  (output a, b, gate_en, freeze, load, mode, load_val, input count);
    modport chan (input a, b, gate_en, freeze, load, mode, load_val, output count);
endinterface

// File: inc/enccl_pkg.sv
/*
 * enccl_pkg - types shared by the encoder counter/latch modules.
 * Assumes: enccl_cfg.svh on the include path.
 */
`include "enccl_cfg.svh"

package enccl_pkg;
    typedef enum logic {
        ENCCL_MODE_ENCODER,
        ENCCL_MODE_COUNTER
    } enccl_mode_type;

    typedef logic [`ENCCL_CNT_W-1:0] enccl_count_type;
endpackage

// File: verification/enccl_enc_model.sv
/*
 * enccl_enc_model.sv - behavioural incremental encoder on the field side:
 * two quadrature track pairs, zero mark, gate/latch level and pulse output.
 * Assumes: the bench calls its tasks; pins change by nba right after a rising edge.
 */
`timescale 1ns/1ps

module enccl_enc_model (
    input  wire logic clk_in,
    output logic      a_out,
    output logic      b_out,
    output logic      c_out,
    output logic      gate_out,
    output logic      a2_out,
    output logic      b2_out
);
    // ======================================================================
    // track state
    logic [1:0]  seq [4] = '{2'h0, 2'h2, 2'h3, 2'h1}; // a leads going up
    logic [1:0]  ph  [2] = '{2'h0, 2'h0};
    int unsigned hold    = 5;

    initial begin
        {a_out, b_out, c_out, gate_out, a2_out, b2_out} = 6'h00;
    end

    // ======================================================================
    // stimulus tasks
    // hold below 3 cycles risks the synchroniser dropping a state
    task automatic settle();
        repeat (hold) @(posedge clk_in);
    endtask

    // jump moves two states so both tracks flip in one sample
    task automatic step(input int ch, input bit up, input bit jump);
        @(posedge clk_in);
        ph[ch] = jump ? ph[ch] + 2'h2 : (up ? ph[ch] + 2'h1 : ph[ch] - 2'h1);
        if (ch == 0) begin
            {a_out, b_out} <= seq[ph[ch]];
        end else begin
            {a2_out, b2_out} <= seq[ph[ch]];
        end
        settle();
    endtask

    // pin 0 zero mark, 1 gate, 2 direction track
    task automatic level(input int pin, input logic v);
        @(posedge clk_in);
        case (pin)
            0: c_out <= v;
            1: gate_out <= v;
            default: b_out <= v;
        endcase
        settle();
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_in);
            a_out <= 1'b1;
            settle();
            @(posedge clk_in);
            a_out <= 1'b0;
            settle();
        end
    endtask
endmodule

// File: verification/enccl_tb_top.sv
/*
 * enccl_tb_top.sv - self-checking bench: ahb-lite register access plus
 * encoder model stimulus for both channels and both modes.
 * Assumes: package, interface and design compiled first; one bus master.
 */
`timescale 1ns/1ps
`include "enccl_cfg.svh"

module enccl_tb_top;
    // ======================================================================
    // signals
    logic        mclk   = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        a, b, c, gate, a2, b2;
    int          bad_count  = 0;
    int          num_checks = 0;
    logic [31:0] exp_latch;
    int          lt_pin [7] = '{0, 0, 0, 1, 1, 1, 1};
    int          lt_bit [7] = '{0, 0, 3, 3, 3, 4, 4};
    logic        lt_lvl [7] = '{1, 0, 1, 1, 0, 1, 0};
    logic        lt_hit [7] = '{1, 0, 0, 1, 0, 0, 1};

    always #4 mclk = ~mclk;

    enccl_top uut (
        .MCLK_IN(mclk), .ARST_N_IN(arst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
        .HRESP_OUT(hresp), .ENC_A_IN(a), .ENC_B_IN(b), .ENC_C_IN(c), .GATE_IN(gate),
        .ENC_A2_IN(a2), .ENC_B2_IN(b2)
    );

    enccl_enc_model u_enc (
        .clk_in(mclk), .a_out(a), .b_out(b), .c_out(c), .gate_out(gate),
        .a2_out(a2), .b2_out(b2)
    );

    // ======================================================================
    // checking and bus tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            $display("[ERR] hready expected 1 seen %b", hreadyout);
            summarize();
        end
    endtask

    task automatic xfer(input logic [7:0] addr, input logic wr_en, input logic [31:0] wd,
                        output logic [31:0] rdat);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h00_0000, addr};
        hwrite <= wr_en;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] dummy;
        xfer(addr, 1'b1, wd, dummy);
    endtask

    task automatic rdc(input string name, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] v;
        xfer(addr, 1'b0, 32'h0, v);
        chk(name, v, exp);
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        rdc("ctrl", `ENCCL_ADDR_CTRL, 32'h0);
        rdc("feature", `ENCCL_ADDR_FEATURE, 32'h0);
        rdc("latch", `ENCCL_ADDR_LATCH, 32'h0);
        rdc("status", `ENCCL_ADDR_STATUS, 32'h0);
        wr(8'h18, 32'hA5A5_A5A5);
        rdc("unmapped", 8'h18, 32'h0);
        $display("test reset done");

        u_enc.hold = 3;
        repeat (4) u_enc.step(1, 1'b1, 1'b0);
        u_enc.hold = 9;
        u_enc.step(1, 1'b0, 1'b0);
        u_enc.hold = 5;
        rdc("count2", `ENCCL_ADDR_COUNT2, 32'h3);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h0);
        $display("test second channel done");

        repeat (5) u_enc.step(0, 1'b1, 1'b0);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h5);
        repeat (7) u_enc.step(0, 1'b0, 1'b0);
        rdc("count", `ENCCL_ADDR_COUNT, 32'hFFFF_FFFE);
        u_enc.step(0, 1'b0, 1'b1);
        rdc("count", `ENCCL_ADDR_COUNT, 32'hFFFF_FFFE);
        wr(`ENCCL_ADDR_COUNT, 32'hFFFF_FFFF);
        rdc("count", `ENCCL_ADDR_COUNT, 32'hFFFF_FFFF);
        u_enc.step(0, 1'b1, 1'b0);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h0);
        $display("test quadrature done");

        // each row: enable one edge source, move one pin, latch or keep
        exp_latch = 32'h0;
        for (int k = 0; k < 7; k++) begin
            wr(`ENCCL_ADDR_CTRL, 32'h1 << lt_bit[k]);
            wr(`ENCCL_ADDR_COUNT, 32'h100 + k);
            u_enc.level(lt_pin[k], lt_lvl[k]);
            if (lt_hit[k]) begin
                exp_latch = 32'h100 + k;
            end
            rdc("latch", `ENCCL_ADDR_LATCH, exp_latch);
        end
        rdc("status", `ENCCL_ADDR_STATUS, 32'hB);
        wr(`ENCCL_ADDR_STATUS, 32'h1);
        rdc("status", `ENCCL_ADDR_STATUS, 32'hA);
        $display("test latch done");

        wr(`ENCCL_ADDR_CTRL, 32'h0);
        wr(`ENCCL_ADDR_COUNT, 32'h0);
        wr(`ENCCL_ADDR_FEATURE, 32'h1 << `ENCCL_FEAT_LOCK_HIGH);
        u_enc.level(1, 1'b1);
        repeat (2) u_enc.step(0, 1'b1, 1'b0);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h0);
        u_enc.level(1, 1'b0);
        repeat (2) u_enc.step(0, 1'b1, 1'b0);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h2);
        wr(`ENCCL_ADDR_FEATURE, 32'h1 << `ENCCL_FEAT_LOCK_LOW);
        repeat (3) u_enc.step(0, 1'b1, 1'b0);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h2);
        $display("test gate lock done");

        wr(`ENCCL_ADDR_FEATURE, 32'h1 << `ENCCL_FEAT_MODE);
        u_enc.level(2, 1'b0);
        u_enc.pulse(3);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h5);
        u_enc.level(2, 1'b1);
        u_enc.pulse(2);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h3);
        u_enc.level(0, 1'b0);
        u_enc.pulse(2);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h3);
        wr(`ENCCL_ADDR_CTRL, 32'h19);
        u_enc.level(1, 1'b1);
        u_enc.level(1, 1'b0);
        rdc("latch", `ENCCL_ADDR_LATCH, 32'h106);
        rdc("count", `ENCCL_ADDR_COUNT, 32'h3);
        $display("test counter mode done");
        summarize();
    end
endmodule
